// ---- qsc_pkg.sv ----
// Overview of operation
// - power-down pin high shuts reference, reference buffer, PLL and bias off
// - in power-down every serial output driver is high impedance
// - power-down pin low returns the device to normal conversion and output
// - wake-up time scales with time spent down, about 4 ms after 1 s
// - PLL multiplies sample clock for shifting; sample rate at least 10 MSPS
// - abrupt rate change may unlock PLL, invalidating clocks and data outputs
// - non-sampling edge retimed so the internal clock has 50% duty cycle
// - 12-bit words, MSB first, offset binary: +FS ones, zero midscale, -FS zeros
// - analog input is sampled on the rising edge of the sample clock
// - each converter on its own lane, 12 bits per sample, bit clock DDR at 6x
// - frame clock runs at sample rate and marks the start of each word
// - test-pattern mode shifts a fixed midscale or alternating word on all lanes
`default_nettype none

package qsc_pkg;

	localparam int LANES      = 4;
	localparam int WORD_BITS  = 12;
	localparam int FIFO_DEPTH = 8;

	// -------------------------------------------------------------
	// timing
	// -------------------------------------------------------------
	localparam int CLK_SYS_MHZ       = 250;
	localparam int WAKE_TIME_US      = 4000;
	localparam int DISCHARGE_TIME_MS = 1000;
	localparam int WAKE_CYCLES       = WAKE_TIME_US * CLK_SYS_MHZ;
	localparam int DISCHARGE_CYCLES  = DISCHARGE_TIME_MS * 1000 * CLK_SYS_MHZ;
	// down cycles that add one cycle of wake-up
	localparam int DISCHARGE_RATIO   = DISCHARGE_CYCLES / WAKE_CYCLES;

	// -------------------------------------------------------------
	// output codes and patterns
	// -------------------------------------------------------------
	localparam logic [WORD_BITS-1:0] CODE_MIDSCALE = 12'h800;
	localparam logic [WORD_BITS-1:0] PATTERN_MID   = 12'h800;
	localparam logic [WORD_BITS-1:0] PATTERN_ALT   = 12'hAAA;
	localparam logic [WORD_BITS-1:0] OB_MSB_FLIP   = 12'h800;

	// frame: one link cycle per data bit, two link cycles per bit clock period
	localparam logic [3:0] BIT_LAST   = 4'h0b;
	localparam logic [3:0] FRAME_HIGH = 4'h6;

	typedef enum logic [1:0]
	{
		QSC_TP_NORMAL     = 2'h0,
		QSC_TP_MIDSCALE   = 2'h1,
		QSC_TP_ALTERNATE  = 2'h2,
		QSC_TP_RESTRICTED = 2'h3
	} qsc_tp_t;

	// one conversion of all four converters, two's complement from the core
	typedef struct packed
	{
		logic [LANES-1:0][WORD_BITS-1:0] word;
	} qsc_sample_t;

	typedef struct packed
	{
		logic             bit_clock;
		logic             frame_clock;
		logic [LANES-1:0] data;
	} qsc_link_t;

endpackage

`default_nettype wire

// ---- qsc_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

module qsc_fifo
#(
	parameter int WIDTH = 48,
	parameter int DEPTH = 8
)
(
	input  wire logic             clk_sys_i,
	input  wire logic             nrst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;

	wire push = in_valid_i & in_ready_o;
	wire pop  = out_valid_o & out_ready_i;

	assign in_ready_o  = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o  = mem[rd_ptr];

	always_ff @(posedge clk_sys_i)
	begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule

`default_nettype wire

// ---- qsc_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module qsc_top
#(
	parameter int WAKE_CYCLES      = qsc_pkg::WAKE_CYCLES,
	parameter int DISCHARGE_RATIO  = qsc_pkg::DISCHARGE_RATIO
)
(
	input  wire logic                    clk_sys_i,
	input  wire logic                    nrst_i,
	input  wire logic                    clk_link_i,
	input  wire logic                    power_down_pin_i,
	input  wire logic [1:0]              test_pattern_select_i,
	input  wire logic                    pll_locked_i,
	input  wire logic                    sample_valid_i,
	input  wire qsc_pkg::qsc_sample_t    sample_i,
	output logic                         ref_enable_o,
	output logic                         pll_enable_o,
	output logic                         bias_enable_o,
	output logic                         link_active_o,
	output logic                         sample_drop_o,
	output logic [qsc_pkg::LANES-1:0]    lane_data_o,
	output logic [qsc_pkg::LANES-1:0]    lane_data_oe_o,
	output logic                         bit_clock_out_o,
	output logic                         bit_clock_out_oe_o,
	output logic                         frame_clock_out_o,
	output logic                         frame_clock_out_oe_o
);

	localparam int SW = $bits(qsc_pkg::qsc_sample_t);

	typedef enum logic [1:0]
	{
		QSC_ST_WAKE,
		QSC_ST_RUN,
		QSC_ST_DOWN
	} qsc_state_t;

	// -------------------------------------------------------------
	// pin synchronisers, system domain
	// -------------------------------------------------------------
	logic       pd_s1;
	logic       pd_s2;
	logic       lock_s1;
	logic       lock_s2;
	logic       ack_s1;
	logic       ack_s2;
	logic       ack_tgl;

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			pd_s1   <= 1'b0;
			pd_s2   <= 1'b0;
			lock_s1 <= 1'b0;
			lock_s2 <= 1'b0;
			ack_s1  <= 1'b0;
			ack_s2  <= 1'b0;
		end
		else
		begin
			pd_s1   <= power_down_pin_i;
			pd_s2   <= pd_s1;
			lock_s1 <= pll_locked_i;
			lock_s2 <= lock_s1;
			ack_s1  <= ack_tgl;
			ack_s2  <= ack_s1;
		end
	end

	// -------------------------------------------------------------
	// power sequencing
	// -------------------------------------------------------------
	qsc_state_t  state;
	qsc_state_t  next_state;
	logic [31:0] wake_left;
	logic [31:0] next_wake_left;
	logic [31:0] down_div;
	logic [31:0] next_down_div;

	// wake budget grows one cycle per DISCHARGE_RATIO cycles spent down
	wire         div_wrap   = (down_div == 32'(DISCHARGE_RATIO - 1));
	wire         wake_done  = (wake_left == '0);
	wire         budget_max = (wake_left == 32'(WAKE_CYCLES));

	always_comb
	begin
		next_state     = state;
		next_wake_left = wake_left;
		next_down_div  = down_div;
		unique case (state)
			QSC_ST_DOWN:
			begin
				next_down_div = div_wrap ? '0 : down_div + 32'h0000_0001;
				if (div_wrap && !budget_max)
					next_wake_left = wake_left + 32'h0000_0001;
				if (!pd_s2)
					next_state = QSC_ST_WAKE;
			end
			QSC_ST_WAKE:
			begin
				if (pd_s2)
					next_state = QSC_ST_DOWN;
				else if (!wake_done)
					next_wake_left = wake_left - 32'h0000_0001;
				else if (lock_s2)
					next_state = QSC_ST_RUN;
			end
			QSC_ST_RUN:
			begin
				next_down_div = '0;
				if (pd_s2)
					next_state = QSC_ST_DOWN;
				else if (!lock_s2)
					next_state = QSC_ST_WAKE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			state     <= QSC_ST_WAKE;
			wake_left <= 32'(WAKE_CYCLES);
			down_div  <= '0;
		end
		else
		begin
			state     <= next_state;
			wake_left <= next_wake_left;
			down_div  <= next_down_div;
		end
	end

	wire next_powered = (next_state != QSC_ST_DOWN);
	wire next_run     = (next_state == QSC_ST_RUN);

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			ref_enable_o  <= 1'b1;
			pll_enable_o  <= 1'b1;
			bias_enable_o <= 1'b1;
			link_active_o <= 1'b0;
		end
		else
		begin
			ref_enable_o  <= next_powered;
			pll_enable_o  <= next_powered;
			bias_enable_o <= next_powered;
			link_active_o <= next_run;
		end
	end

	// -------------------------------------------------------------
	// sample capture and buffering
	// -------------------------------------------------------------
	qsc_pkg::qsc_sample_t cap_word;
	logic                 cap_valid;
	logic                 fifo_in_ready;
	logic                 fifo_out_valid;
	logic [SW-1:0]        fifo_out_data;
	logic                 pending;
	qsc_pkg::qsc_sample_t hold_word;
	logic                 req_tgl;

	wire running   = (state == QSC_ST_RUN);
	wire cap_push  = cap_valid & fifo_in_ready;
	wire cap_free  = !cap_valid | fifo_in_ready;
	wire cap_take  = sample_valid_i & running & cap_free;
	wire cap_lost  = sample_valid_i & running & !cap_free;
	wire fifo_pop  = fifo_out_valid & !pending;

	// capture on the rising sample edge; a full path drops rather than stalls the converter
	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			cap_valid     <= 1'b0;
			cap_word      <= '0;
			sample_drop_o <= 1'b0;
		end
		else
		begin
			if (cap_take)
				cap_word <= sample_i;
			cap_valid     <= cap_take | (cap_valid & !cap_push & running);
			sample_drop_o <= cap_lost;
		end
	end

	qsc_fifo
	#(
		.WIDTH (SW),
		.DEPTH (qsc_pkg::FIFO_DEPTH)
	)
	u_fifo
	(
		.clk_sys_i   (clk_sys_i),
		.nrst_i      (nrst_i & running),
		.in_valid_i  (cap_valid),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (cap_word),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (!pending),
		.out_data_o  (fifo_out_data)
	);

	// -------------------------------------------------------------
	// word handshake toward the link domain
	// -------------------------------------------------------------
	// hold_word stays still while a request is open, so the link side may read it directly
	assign pending = (req_tgl != ack_s2);

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			req_tgl   <= 1'b0;
			hold_word <= '0;
		end
		else if (fifo_pop)
		begin
			req_tgl   <= !req_tgl;
			hold_word <= qsc_pkg::qsc_sample_t'(fifo_out_data);
		end
	end

	// -------------------------------------------------------------
	// link domain: reset, enable and request synchronisers
	// -------------------------------------------------------------
	logic       lrst_s1;
	logic       lrst_s2;
	logic       on_s1;
	logic       on_s2;
	logic       req_s1;
	logic       req_s2;
	logic [1:0] tp_s1;
	logic [1:0] tp_s2;

	always_ff @(posedge clk_link_i)
	begin
		lrst_s1 <= nrst_i;
		lrst_s2 <= lrst_s1;
	end

	always_ff @(posedge clk_link_i)
	begin
		if (!lrst_s2)
		begin
			on_s1  <= 1'b0;
			on_s2  <= 1'b0;
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			tp_s1  <= '0;
			tp_s2  <= '0;
		end
		else
		begin
			on_s1  <= link_active_o;
			on_s2  <= on_s1;
			req_s1 <= req_tgl;
			req_s2 <= req_s1;
			tp_s1  <= test_pattern_select_i;
			tp_s2  <= tp_s1;
		end
	end

	// -------------------------------------------------------------
	// serializer
	// -------------------------------------------------------------
	logic [3:0]                                        bit_idx;
	logic [qsc_pkg::LANES-1:0][qsc_pkg::WORD_BITS-1:0] shift;
	qsc_pkg::qsc_link_t                                link;
	logic [qsc_pkg::LANES-1:0][qsc_pkg::WORD_BITS-1:0] load_word;
	logic [qsc_pkg::LANES-1:0][qsc_pkg::WORD_BITS-1:0] last_word;
	logic [qsc_pkg::LANES-1:0][qsc_pkg::WORD_BITS-1:0] data_word;

	wire       new_word  = (req_s2 != ack_tgl);
	wire       frame_end = (bit_idx == qsc_pkg::BIT_LAST);
	wire       pat_mid   = (tp_s2 == qsc_pkg::QSC_TP_MIDSCALE);
	wire       pat_alt   = (tp_s2 == qsc_pkg::QSC_TP_ALTERNATE);

	genvar g;
	generate
		for (g = 0; g < qsc_pkg::LANES; g++)
		begin : g_lane
			// offset binary is two's complement with the sign bit inverted
			wire [qsc_pkg::WORD_BITS-1:0] ob = new_word ?
				(hold_word.word[g] ^ qsc_pkg::OB_MSB_FLIP) : last_word[g];
			assign data_word[g] = ob;
			assign load_word[g] = pat_mid ? qsc_pkg::PATTERN_MID :
				pat_alt ? qsc_pkg::PATTERN_ALT : ob;
			assign link.data[g] = shift[g][qsc_pkg::WORD_BITS-1];
		end
	endgenerate

	// bit clock toggles every link cycle, so one edge per bit and a 50% duty by construction
	assign link.bit_clock   = !bit_clock_out_o;
	// high over bits 0..5, so the registered copy rises together with the msb on the lanes
	assign link.frame_clock = (bit_idx < qsc_pkg::FRAME_HIGH);

	always_ff @(posedge clk_link_i)
	begin
		if (!lrst_s2 || !on_s2)
		begin
			bit_idx   <= qsc_pkg::BIT_LAST;
			shift     <= '0;
			ack_tgl   <= req_s2;
			last_word <= {qsc_pkg::LANES{qsc_pkg::CODE_MIDSCALE}};
		end
		else if (frame_end)
		begin
			bit_idx   <= '0;
			shift     <= load_word;
			// a test pattern must not replace the data word that repeats afterwards
			last_word <= data_word;
			ack_tgl   <= req_s2;
		end
		else
		begin
			bit_idx <= bit_idx + 4'h1;
			for (int i = 0; i < qsc_pkg::LANES; i++)
				shift[i] <= {shift[i][qsc_pkg::WORD_BITS-2:0], 1'b0};
		end
	end

	// all pin drivers come from flops; enables drop while powered down or waking
	always_ff @(posedge clk_link_i)
	begin
		if (!lrst_s2 || !on_s2)
		begin
			lane_data_o          <= '0;
			bit_clock_out_o      <= 1'b0;
			frame_clock_out_o    <= 1'b0;
			lane_data_oe_o       <= '0;
			bit_clock_out_oe_o   <= 1'b0;
			frame_clock_out_oe_o <= 1'b0;
		end
		else
		begin
			lane_data_o          <= link.data;
			bit_clock_out_o      <= link.bit_clock;
			frame_clock_out_o    <= link.frame_clock;
			lane_data_oe_o       <= '1;
			bit_clock_out_oe_o   <= 1'b1;
			frame_clock_out_oe_o <= 1'b1;
		end
	end

endmodule

`default_nettype wire

// ---- qsc_chk_sva.sv ----
`timescale 1ns/1ps
`default_nettype none

module qsc_chk
#(
	parameter int WAKE_CYCLES     = 20,
	parameter int DISCHARGE_RATIO = 4
)
(
	input wire logic       clk_sys_i,
	input wire logic       nrst_i,
	input wire logic       clk_link_i,
	input wire logic       power_down_pin_i,
	input wire logic       ref_enable_o,
	input wire logic       pll_enable_o,
	input wire logic       bias_enable_o,
	input wire logic       link_active_o,
	input wire logic [3:0] lane_data_o,
	input wire logic [3:0] lane_data_oe_o,
	input wire logic       bit_clock_out_o,
	input wire logic       bit_clock_out_oe_o,
	input wire logic       frame_clock_out_o,
	input wire logic       frame_clock_out_oe_o
);
	// ------------
	// frame shape
	// ------------
	sequence s_fr_high;
		frame_clock_out_o [*6];
	endsequence
	sequence s_fr_low;
		!frame_clock_out_o [*6];
	endsequence

	AST_PD_OFF: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		power_down_pin_i [*6] |-> !ref_enable_o && !link_active_o)
		else $error("powered down but still enabled");
	AST_EN_TIE: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		ref_enable_o == pll_enable_o && pll_enable_o == bias_enable_o)
		else $error("enables disagree");
	AST_EN_BACK: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		!power_down_pin_i [*6] |-> ref_enable_o)
		else $error("enables still off after pin low");
	// link outputs sample the other domain's state; five link edges cover the two-stage sync
	AST_HIZ: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
		!link_active_o [*5] |-> !frame_clock_out_oe_o && lane_data_oe_o == '0
		&& lane_data_o == '0 && !bit_clock_out_o)
		else $error("link driven while not running");
	AST_OE_ON: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
		link_active_o [*5] |-> frame_clock_out_oe_o && bit_clock_out_oe_o)
		else $error("link not driven while running");
	AST_OE_SAME: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
		lane_data_oe_o == {4{bit_clock_out_oe_o}} && frame_clock_out_oe_o == bit_clock_out_oe_o)
		else $error("output enables disagree");
	AST_BCLK: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
		bit_clock_out_oe_o [*3] |-> bit_clock_out_o != $past(bit_clock_out_o))
		else $error("bit clock missed a toggle");
	AST_FRAME: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
		$rose(frame_clock_out_o) |-> (s_fr_high ##1 s_fr_low ##1 frame_clock_out_o)
		or (##[1:13] !frame_clock_out_oe_o))
		else $error("frame clock not six high six low");
endmodule

bind qsc_top qsc_chk #(.WAKE_CYCLES(WAKE_CYCLES), .DISCHARGE_RATIO(DISCHARGE_RATIO)) u_chk
(
	.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .clk_link_i(clk_link_i),
	.power_down_pin_i(power_down_pin_i), .ref_enable_o(ref_enable_o),
	.pll_enable_o(pll_enable_o), .bias_enable_o(bias_enable_o), .link_active_o(link_active_o),
	.lane_data_o(lane_data_o), .lane_data_oe_o(lane_data_oe_o),
	.bit_clock_out_o(bit_clock_out_o), .bit_clock_out_oe_o(bit_clock_out_oe_o),
	.frame_clock_out_o(frame_clock_out_o), .frame_clock_out_oe_o(frame_clock_out_oe_o)
);

`default_nettype wire

// ---- qsc_rx_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module qsc_rx_model
(
	input  wire logic       clk_link_i,
	input  wire logic [3:0] lane_i,
	input  wire logic [3:0] lane_oe_i,
	input  wire logic       frame_i,
	input  wire logic       frame_oe_i,
	output logic            rx_valid_o,
	output qsc_pkg::qsc_sample_t rx_word_o
);
	// ------------
	// receiver
	// ------------
	logic [3:0] cnt;
	logic [3:0] lane_q;
	logic       fr_q;
	logic       armed;
	qsc_pkg::qsc_sample_t sh;
	qsc_pkg::qsc_sample_t next_sh;
	// an undriven lane has no pull, so it reads as the inverse of its last level
	wire logic [3:0] lane_w = (lane_oe_i & lane_i) | (~lane_oe_i & ~lane_q);

	always_comb
	begin
		for (int g = 0; g < 4; g++)
			next_sh.word[g] = {sh.word[g][10:0], lane_w[g]};
	end

	always_ff @(posedge clk_link_i)
	begin
		lane_q <= lane_w;
		fr_q <= frame_i;
		sh <= next_sh;
		cnt <= (frame_i && !fr_q) ? 4'h1 : cnt + 4'h1;
		armed <= frame_oe_i && (armed || (frame_i && !fr_q));
		rx_valid_o <= frame_oe_i && armed && cnt == 4'hb;
		rx_word_o <= next_sh;
	end
endmodule

`default_nettype wire

// ---- quad_adc_serial_output_ctrl_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module quad_adc_serial_output_ctrl_bench;
	localparam int WAKE = 20;
	localparam int RATIO = 4;
	localparam logic [47:0] FLIP = 48'h8008_0080_0800;
	logic clk_sys, clk_link, nrst, pd, lock, sv, mon_en, rx_valid;
	logic ref_en, pll_en, bias_en, active, drop, bclk, bclk_oe, fclk, fclk_oe;
	logic [1:0] tp;
	logic [3:0] lane, lane_oe;
	qsc_pkg::qsc_sample_t smp, rx_word, last_rx;
	qsc_pkg::qsc_sample_t burst[12];
	qsc_pkg::qsc_sample_t exp_q[$];
	int errors, num_checks, drops, n;

	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial
	begin
		clk_link = 1'b0;
		#1.3;
		forever #7.5 clk_link = ~clk_link;
	end

	qsc_top #(.WAKE_CYCLES(WAKE), .DISCHARGE_RATIO(RATIO)) dut
	(
		.clk_sys_i(clk_sys), .nrst_i(nrst), .clk_link_i(clk_link), .power_down_pin_i(pd),
		.test_pattern_select_i(tp), .pll_locked_i(lock), .sample_valid_i(sv), .sample_i(smp),
		.ref_enable_o(ref_en), .pll_enable_o(pll_en), .bias_enable_o(bias_en),
		.link_active_o(active), .sample_drop_o(drop), .lane_data_o(lane),
		.lane_data_oe_o(lane_oe), .bit_clock_out_o(bclk), .bit_clock_out_oe_o(bclk_oe),
		.frame_clock_out_o(fclk), .frame_clock_out_oe_o(fclk_oe)
	);
	qsc_rx_model u_rx
	(
		.clk_link_i(clk_link), .lane_i(lane), .lane_oe_i(lane_oe), .frame_i(fclk),
		.frame_oe_i(fclk_oe), .rx_valid_o(rx_valid), .rx_word_o(rx_word)
	);

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk_word(input qsc_pkg::qsc_sample_t got, input qsc_pkg::qsc_sample_t want);
		num_checks++;
		if (got !== want)
		begin
			errors++;
			$display("[ERR] %0t word %h want %h", $time, got, want);
		end
	endtask
	task automatic chk_bit(input logic ok, input string what);
		num_checks++;
		if (ok !== 1'b1)
		begin
			errors++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask
	task automatic wait_act(input logic v);
		n = 0;
		while (active !== v && n < 400)
		begin
			step(1);
			n++;
		end
		if (n == 400)
		begin
			errors++;
			$display("[ERR] %0t timeout", $time);
			finish_test();
		end
	endtask
	// ample spacing so every word owns at least one whole frame
	task automatic send(input qsc_pkg::qsc_sample_t w);
		smp = w;
		exp_q.push_back(w ^ FLIP);
		sv = 1'b1;
		step(1);
		sv = 1'b0;
		step(150);
		chk_bit(exp_q.size() == 0, "word missing");
	endtask

	// ------------
	// scoreboard
	// ------------
	// repeats of the held word are not results; only a change counts as a new word
	always @(posedge clk_link)
	begin
		if (rx_valid === 1'b1)
		begin
			if (mon_en && rx_word !== last_rx)
			begin
				if (exp_q.size() == 0)
					chk_word(rx_word, last_rx);
				else
					chk_word(rx_word, exp_q.pop_front());
			end
			last_rx = rx_word;
		end
	end
	always @(posedge clk_sys)
		if (drop === 1'b1)
			drops++;

	initial
	begin
		{nrst, pd, sv, mon_en} = 4'h0;
		lock = 1'b1;
		tp = 2'h0;
		smp = '0;
		// the lanes come up repeating midscale, which is not a new result
		last_rx = FLIP;
		errors = 0;
		num_checks = 0;
		drops = 0;
		void'($urandom(70631));
		step(16);
		nrst = 1'b1;
		wait_act(1'b1);
		chk_bit(n >= WAKE && n <= WAKE + 9, "first wake");
		mon_en = 1'b1;
		send(48'h7ff8_0000_0fff);
		for (int i = 0; i < 4; i++)
			send(48'({$urandom, $urandom}));
		for (int m = 1; m < 4; m++)
		begin
			exp_q.push_back(m == 1 ? FLIP : m == 2 ? 48'haaaa_aaaa_aaaa : smp ^ FLIP);
			tp = 2'(m);
			step(150);
			chk_bit(exp_q.size() == 0, "pattern");
		end
		tp = 2'h0;
		chk_bit(drops == 0, "spurious drop");
		sv = 1'b1;
		for (int i = 0; i < 12; i++)
		begin
			burst[i] = 48'({$urandom, $urandom});
			smp = burst[i];
			step(1);
		end
		sv = 1'b0;
		step(4);
		chk_bit(drops > 0, "no refusal");
		for (int i = 0; i < 12 - drops; i++)
			exp_q.push_back(burst[i] ^ FLIP);
		step(700);
		chk_bit(exp_q.size() == 0, "burst lost");
		mon_en = 1'b0;
		for (int k = 0; k < 2; k++)
		begin
			pd = 1'b1;
			step(k ? 200 : 24);
			chk_bit(ref_en === 1'b0 && pll_en === 1'b0 && bias_en === 1'b0, "still on");
			chk_bit(lane_oe === 4'h0 && bclk_oe === 1'b0 && fclk_oe === 1'b0, "driven");
			pd = 1'b0;
			wait_act(1'b1);
			chk_bit(n + 2 >= (k ? WAKE : 6) && n <= (k ? WAKE : 6) + 9, "wake");
		end
		lock = 1'b0;
		wait_act(1'b0);
		chk_bit(n <= 8, "lock loss");
		step(20);
		lock = 1'b1;
		wait_act(1'b1);
		chk_bit(n <= 8, "relock");
		step(150);
		mon_en = 1'b1;
		send(48'({$urandom, $urandom}));
		finish_test();
	end
endmodule

`default_nettype wire
